// *** design/host_irq_pkg.sv ***
// Register map, field positions and reset values of the host interrupt block
package host_irq_pkg;
   localparam int EVT_W = 88;
   localparam int STAT_W = 40;
   localparam logic [7:0] OFS_ENABLE = 8'h16;
   localparam logic [7:0] OFS_CLEAR = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1a;
   localparam logic [7:0] OFS_EVENTS = 8'h14;
   localparam logic [87:0] ENABLE_RESET = 88'h0;
   localparam logic [87:0] EVENTS_RESET = 88'h8;
   localparam logic [39:0] STATUS_RESET = 40'h0;
   // Bits 83-87 and all reserved positions read and write as zero
   localparam logic [87:0] EVT_IMPL = 88'h07_0006_1308_4CDF_4DB6_723A;
   localparam int BYTE_DEFAULT_LO = 80;
   localparam int BYTE_DEFAULT_HI = 87;
   localparam int EVT_HARD_RESET = 1;
   localparam int EVT_CMD_DONE = 30;
   localparam int EVT_MISSING_CAPS = 36;
   localparam int ST_SOC_TIMEOUT = 30;
   localparam int ST_BIST = 27;
   localparam int ST_LEGACY_LO = 24;
   localparam int ST_HOST_LO = 22;
   localparam int ST_VBUS_LO = 20;
   localparam int ST_DATA_ROLE = 6;
   localparam int ST_PORT_ROLE = 5;
   localparam int ST_ORIENT = 4;
   localparam int ST_CONN_LO = 1;
   localparam logic [2:0] CONN_RESERVED = 3'h5;
   localparam logic [1:0] LEGACY_RESERVED = 2'h2;
endpackage

// *** design/pd_host_irq_mask_clear_status.sv ***
// Host event flags, enable mask, write-one clear and port status register
//
// Summary of operation
// - Event bit 1 sets after a hard reset; cause readable elsewhere.
// - Enable register at 16h, 88 bits, reserved positions read zero.
// - Top byte enables active by default; lower bytes need customization or an enable register write.
// - Clear register at 18h; each 1 written removes that event flag unless the event sets again in the same cycle.
// - Interrupt line low when any flag set; only enabled events latch.
// - Enable and clear bits sit at the same positions as events.
// - Read-only 40-bit status at 1Ah reporting non-event state.
// - Status bit 30 shows the system-on-chip answered too late.
// - Status bit 27 shows a self-test is running.
// - Status 25-24 give legacy mode: none, source, dead-battery sink.
// - Legacy decision may take about ten seconds after attach.
// - Status 23-22 give host attachment kind.
// - Status 21-20 give VBUS range code.
// - Status bit 6 gives data role, valid only when connected.
// - Status bit 5 gives power role; steady while unattached.
// - Status bit 4 gives plug orientation once connected.
// - Status 3-1 give connection state code.
`timescale 1ns/1ps
module pd_host_irq_mask_clear_status
   import host_irq_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [87:0] reg_wdata,
   output logic [87:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [87:0] event_in,
   input wire logic [87:0] custom_enable,
   input wire logic hard_reset_done,
   input wire logic cmd_done,
   input wire logic soc_ack_late,
   input wire logic bist_active,
   input wire logic [1:0] legacy_mode,
   input wire logic [1:0] host_present,
   input wire logic [1:0] vbus_range,
   input wire logic connected,
   input wire logic data_role_dfp,
   input wire logic port_role_src,
   input wire logic unattached,
   input wire logic orient_cc2,
   input wire logic [2:0] conn_state,
   output logic host_irq_n
);
   logic [87:0] host_event_enable;
   logic [87:0] host_event_clear;
   logic [87:0] host_event_flags;
   logic [39:0] port_status;
   logic [87:0] raw_events;
   logic [87:0] eff_enable;
   logic [87:0] clr_now;
   logic [87:0] next_flags;
   logic [39:0] next_status;
   logic status_changed;

   // Raw event vector with the named sources folded in
   always_comb begin
      raw_events = event_in;
      raw_events[EVT_HARD_RESET] = event_in[EVT_HARD_RESET] |
         hard_reset_done;
      raw_events[EVT_CMD_DONE] = event_in[EVT_CMD_DONE] | cmd_done;
      raw_events[26] = event_in[26] | status_changed;
      raw_events = raw_events & EVT_IMPL;
   end

   // Top byte always on; lower bytes only from customization or software
   genvar gi;
   generate
      for (gi = 0; gi < EVT_W; gi++) begin : g_en
         if (gi >= BYTE_DEFAULT_LO && gi <= BYTE_DEFAULT_HI) begin : g_top
            assign eff_enable[gi] = EVT_IMPL[gi];
         end else begin : g_low
            assign eff_enable[gi] = EVT_IMPL[gi] &
               (host_event_enable[gi] | custom_enable[gi]);
         end
      end
   endgenerate

   // Register writes; enable stays plain storage, reset all zeros
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         host_event_enable <= ENABLE_RESET;
      end else if (reg_wr && reg_addr == OFS_ENABLE) begin
         host_event_enable <= reg_wdata & EVT_IMPL;
      end
   end

   assign clr_now = (reg_wr && reg_addr == OFS_CLEAR) ?
      (reg_wdata & EVT_IMPL) : 88'h0;

   // Clear register self-clears so a stale one never blocks a new event
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         host_event_clear <= ENABLE_RESET;
      end else begin
         host_event_clear <= clr_now;
      end
   end

   // Set wins over clear in the same cycle
   assign next_flags = (host_event_flags & ~clr_now) |
      (raw_events & eff_enable);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         host_event_flags <= EVENTS_RESET & eff_enable;
      end else begin
         host_event_flags <= next_flags;
      end
   end

   assign host_irq_n = ~(|host_event_flags);

   // Status assembly; reserved codes and fields read zero
   always_comb begin
      next_status = STATUS_RESET;
      next_status[ST_SOC_TIMEOUT] = soc_ack_late;
      next_status[ST_BIST] = bist_active;
      // Legacy detection is slow and lives upstream, no timer here
      next_status[ST_LEGACY_LO +: 2] =
         (legacy_mode == LEGACY_RESERVED) ? 2'h0 : legacy_mode;
      next_status[ST_HOST_LO +: 2] = host_present;
      next_status[ST_VBUS_LO +: 2] = vbus_range;
      next_status[ST_DATA_ROLE] = connected & data_role_dfp;
      next_status[ST_ORIENT] = connected & orient_cc2;
      next_status[ST_CONN_LO +: 3] =
         (conn_state == CONN_RESERVED) ? 3'h0 : conn_state;
      next_status[ST_PORT_ROLE] = port_status[ST_PORT_ROLE];
      // Hold role while unattached so toggling terminations do not flicker
      if (!unattached) begin
         next_status[ST_PORT_ROLE] = port_role_src;
      end
   end

   assign status_changed = (next_status != port_status);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         port_status <= STATUS_RESET;
      end else begin
         port_status <= next_status;
      end
   end

   // Read port; status is read-only, unmapped offsets read zero
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= 88'h0;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         case (reg_addr)
            OFS_EVENTS: reg_rdata <= host_event_flags;
            OFS_ENABLE: reg_rdata <= host_event_enable;
            OFS_CLEAR: reg_rdata <= host_event_clear;
            OFS_STATUS: reg_rdata <= {48'h0, port_status};
            default: reg_rdata <= 88'h0;
         endcase
      end
   end

   a_clear_removes: assert property (@(posedge ref_clk) disable iff (rst)
      (reg_wr && reg_addr == OFS_CLEAR && reg_wdata[EVT_MISSING_CAPS]
       && !raw_events[EVT_MISSING_CAPS])
      |=> !host_event_flags[EVT_MISSING_CAPS])
      else $error("Clear write did not remove event flag");
   a_set_beats_clear: assert property (@(posedge ref_clk) disable iff (rst)
      (raw_events[EVT_CMD_DONE] && eff_enable[EVT_CMD_DONE])
      |=> host_event_flags[EVT_CMD_DONE])
      else $error("Event lost against clear");
   a_zero_keeps: assert property (@(posedge ref_clk) disable iff (rst)
      (host_event_flags[EVT_HARD_RESET] && !clr_now[EVT_HARD_RESET])
      |=> host_event_flags[EVT_HARD_RESET])
      else $error("Flag dropped without a clear");
   a_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
      host_irq_n == (host_event_flags == 88'h0))
      else $error("Interrupt line disagrees with flags");
   a_masked_quiet: assert property (@(posedge ref_clk) disable iff (rst)
      (!eff_enable[EVT_HARD_RESET] && !host_event_flags[EVT_HARD_RESET])
      |=> !host_event_flags[EVT_HARD_RESET])
      else $error("Masked event latched");
   a_hard_reset_flag: assert property (@(posedge ref_clk) disable iff (rst)
      (hard_reset_done && eff_enable[EVT_HARD_RESET])
      |=> host_event_flags[EVT_HARD_RESET] && !host_irq_n)
      else $error("Hard reset event not flagged");
   a_top_byte_on: assert property (@(posedge ref_clk) disable iff (rst)
      (event_in[81] && !host_event_flags[81])
      |=> host_event_flags[81])
      else $error("Top byte event not enabled by default");
   a_enable_read: assert property (@(posedge ref_clk) disable iff (rst)
      (reg_wr && reg_addr == OFS_ENABLE) ##1 (reg_rd && reg_addr == OFS_ENABLE
       && !reg_wr) |=> reg_rdata == ($past(reg_wdata, 2) & EVT_IMPL))
      else $error("Enable readback mismatch");
   a_port_role_hold: assert property (@(posedge ref_clk) disable iff (rst)
      unattached |=> $stable(port_status[ST_PORT_ROLE]))
      else $error("Port role toggled while unattached");
   a_bist_bit: assert property (@(posedge ref_clk) disable iff (rst)
      bist_active |=> port_status[ST_BIST])
      else $error("Self-test bit not shown");
   a_conn_reserved: assert property (@(posedge ref_clk) disable iff (rst)
      port_status[ST_CONN_LO +: 3] != CONN_RESERVED)
      else $error("Reserved connection code shown");
   a_soc_late: assert property (@(posedge ref_clk) disable iff (rst)
      soc_ack_late |=> port_status[ST_SOC_TIMEOUT])
      else $error("Late acknowledge not shown");

   a_soc_clear: assert property (@(posedge ref_clk) disable iff (rst)
      !soc_ack_late |=> !port_status[ST_SOC_TIMEOUT])
      else $error("Late acknowledge shown while answered");

   a_bist_clear: assert property (@(posedge ref_clk) disable iff (rst)
      !bist_active |=> !port_status[ST_BIST])
      else $error("Self-test bit shown while idle");

   a_legacy_field: assert property (@(posedge ref_clk) disable iff (rst)
      legacy_mode != LEGACY_RESERVED
      |=> port_status[ST_LEGACY_LO +: 2] == $past(legacy_mode))
      else $error("Legacy field mismatch");

   a_legacy_reserved: assert property (@(posedge ref_clk) disable iff (rst)
      legacy_mode == LEGACY_RESERVED
      |=> port_status[ST_LEGACY_LO +: 2] == 2'h0)
      else $error("Undefined legacy code shown");

   a_host_field: assert property (@(posedge ref_clk) disable iff (rst)
      1'b1
      |=> port_status[ST_HOST_LO +: 2] == $past(host_present))
      else $error("Host field mismatch");

   a_vbus_field: assert property (@(posedge ref_clk) disable iff (rst)
      1'b1
      |=> port_status[ST_VBUS_LO +: 2] == $past(vbus_range))
      else $error("Supply range field mismatch");

   a_data_role: assert property (@(posedge ref_clk) disable iff (rst)
      connected
      |=> port_status[ST_DATA_ROLE] == $past(data_role_dfp))
      else $error("Data role mismatch");

   a_role_unconn: assert property (@(posedge ref_clk) disable iff (rst)
      !connected |=> !port_status[ST_DATA_ROLE])
      else $error("Data role shown without connection");

   a_orient_bit: assert property (@(posedge ref_clk) disable iff (rst)
      connected |=> port_status[ST_ORIENT] == $past(orient_cc2))
      else $error("Orientation mismatch");

   a_port_role_track: assert property (@(posedge ref_clk) disable iff (rst)
      !unattached
      |=> port_status[ST_PORT_ROLE] == $past(port_role_src))
      else $error("Port role does not follow");

   a_conn_code: assert property (@(posedge ref_clk) disable iff (rst)
      conn_state != CONN_RESERVED
      |=> port_status[ST_CONN_LO +: 3] == $past(conn_state))
      else $error("Connection code mismatch");

   a_status_reserved: assert property (@(posedge ref_clk) disable iff (rst)
      (port_status[39:31] == 9'h0) && (port_status[29:28] == 2'h0) &&
      !port_status[26] && (port_status[19:7] == 13'h0) &&
      !port_status[0])
      else $error("Reserved status bit set");

   a_status_read: assert property (@(posedge ref_clk) disable iff (rst)
      (reg_rd && reg_addr == OFS_STATUS)
      |=> reg_rdata == {48'h0, $past(port_status)})
      else $error("Status read mismatch");

   a_rvalid_pulse: assert property (@(posedge ref_clk) disable iff (rst)
      reg_rd |=> reg_rvalid)
      else $error("Read not answered");

   a_rvalid_quiet: assert property (@(posedge ref_clk) disable iff (rst)
      !reg_rd |=> !reg_rvalid)
      else $error("Read answer without request");

   a_enable_write: assert property (@(posedge ref_clk) disable iff (rst)
      (reg_wr && reg_addr == OFS_ENABLE)
      |=> host_event_enable == ($past(reg_wdata) & EVT_IMPL))
      else $error("Enable write not stored");

   a_enable_hold: assert property (@(posedge ref_clk) disable iff (rst)
      !(reg_wr && reg_addr == OFS_ENABLE)
      |=> $stable(host_event_enable))
      else $error("Enable changed without a write");

   a_enable_reserved: assert property (@(posedge ref_clk) disable iff (rst)
      (host_event_enable & ~EVT_IMPL) == 88'h0)
      else $error("Reserved enable bit set");

   a_flags_reserved: assert property (@(posedge ref_clk) disable iff (rst)
      (host_event_flags & ~EVT_IMPL) == 88'h0)
      else $error("Reserved event flag set");

   a_clear_selfclr: assert property (@(posedge ref_clk) disable iff (rst)
      !(reg_wr && reg_addr == OFS_CLEAR)
      |=> host_event_clear == 88'h0)
      else $error("Stale clear bits kept");

   a_top_always: assert property (@(posedge ref_clk) disable iff (rst)
      eff_enable[BYTE_DEFAULT_HI:BYTE_DEFAULT_LO] == EVT_IMPL[87:80])
      else $error("Top byte enable missing");

   a_custom_enable: assert property (@(posedge ref_clk) disable iff (rst)
      (custom_enable[EVT_MISSING_CAPS] && event_in[EVT_MISSING_CAPS])
      |=> host_event_flags[EVT_MISSING_CAPS])
      else $error("Customized enable ignored");

   a_cmd_done_flag: assert property (@(posedge ref_clk) disable iff (rst)
      (cmd_done && eff_enable[EVT_CMD_DONE])
      |=> host_event_flags[EVT_CMD_DONE] && !host_irq_n)
      else $error("Command completion not flagged");

   a_missing_caps: assert property (@(posedge ref_clk) disable iff (rst)
      (event_in[EVT_MISSING_CAPS] && eff_enable[EVT_MISSING_CAPS])
      |=> host_event_flags[EVT_MISSING_CAPS])
      else $error("Error event not flagged");

   a_status_event: assert property (@(posedge ref_clk) disable iff (rst)
      ($changed(port_status) && $past(eff_enable[26]))
      |-> host_event_flags[26])
      else $error("Status change not flagged");

   a_flag_hold: assert property (@(posedge ref_clk) disable iff (rst)
      (host_event_flags[EVT_MISSING_CAPS] && !clr_now[EVT_MISSING_CAPS])
      |=> host_event_flags[EVT_MISSING_CAPS])
      else $error("Error flag dropped without a clear");

   a_hr_clear: assert property (@(posedge ref_clk) disable iff (rst)
      (clr_now[EVT_HARD_RESET] && !raw_events[EVT_HARD_RESET])
      |=> !host_event_flags[EVT_HARD_RESET])
      else $error("Hard reset flag not cleared");

   c_clear_flag: cover property (@(posedge ref_clk) disable iff (rst)
      host_event_flags[EVT_CMD_DONE] ##1 !host_event_flags[EVT_CMD_DONE]);
   c_irq_assert: cover property (@(posedge ref_clk) disable iff (rst)
      host_irq_n ##1 !host_irq_n);
   c_collision: cover property (@(posedge ref_clk) disable iff (rst)
      clr_now[EVT_CMD_DONE] && raw_events[EVT_CMD_DONE]);
   c_status_read: cover property (@(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr == OFS_STATUS);
   c_top_byte: cover property (@(posedge ref_clk) disable iff (rst)
      host_event_flags[81]);
endmodule // pd_host_irq_mask_clear_status

// *** verification/host_model.sv ***
// Host processor model driving the register port of the interrupt block
`timescale 1ns/1ps
module host_model (
   input wire logic ref_clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [87:0] reg_wdata,
   input wire logic [87:0] reg_rdata,
   input wire logic reg_rvalid
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = '0;
   end
   // Ones only where a flag should go; zeros leave flags alone
   task automatic wr(input logic [7:0] a, input logic [87:0] dat);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= dat;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      // Released data shows no stale value
      reg_wdata <= ~dat;
   endtask
   task automatic rd(input logic [7:0] a, output logic [87:0] q,
      output logic v);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      q = reg_rdata;
      v = reg_rvalid;
   endtask
endmodule // host_model

// *** verification/testbench.sv ***
// Self-checking bench for event mask, clear and port status logic
`timescale 1ns/1ps
module testbench;
   import host_irq_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr, reg_rd, reg_rvalid, host_irq_n, v;
   logic [7:0] reg_addr;
   logic [87:0] reg_wdata, reg_rdata, d, en;
   logic [87:0] event_in = '0;
   logic [87:0] custom_enable = '0;
   logic hard_reset_done = 1'b0;
   logic cmd_done = 1'b0;
   logic [15:0] s_in = '0;
   int err_count = 0;
   int checks = 0;
   // Status inputs beside the status word they should give
   logic [55:0] rows [4] = '{56'h9E_E700_41E0_006E, 56'h77_6D00_0B70_0020,
      56'h29_8E00_0090_001C, 56'h00_3300_0000_0006};
   always #4 ref_clk = ~ref_clk;
   pd_host_irq_mask_clear_status pd_host_irq_mask_clear_status_inst (
      .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .event_in(event_in),
      .custom_enable(custom_enable), .hard_reset_done(hard_reset_done),
      .cmd_done(cmd_done), .soc_ack_late(s_in[15]), .bist_active(s_in[14]),
      .legacy_mode(s_in[13:12]), .host_present(s_in[11:10]),
      .vbus_range(s_in[9:8]), .connected(s_in[7]), .data_role_dfp(s_in[6]),
      .port_role_src(s_in[5]), .unattached(s_in[4]), .orient_cc2(s_in[3]),
      .conn_state(s_in[2:0]), .host_irq_n(host_irq_n));
   host_model host_model_inst (.ref_clk(ref_clk), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   task automatic chk_word(input string n, input logic [87:0] e, g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic rd_chk(input string n, input logic [7:0] a,
      input logic [87:0] e);
      host_model_inst.rd(a, d, v);
      chk_bit("read valid", 1'b1, v);
      chk_word(n, e, d);
   endtask
   task automatic ev(input logic [87:0] e, input logic hr, cd);
      @(posedge ref_clk);
      event_in <= e;
      hard_reset_done <= hr;
      cmd_done <= cd;
      @(posedge ref_clk);
      event_in <= '0;
      hard_reset_done <= 1'b0;
      cmd_done <= 1'b0;
      #1;
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Hang guard: the run is far shorter than this
   initial begin
      #200000;
      err_count++;
      results;
   end
   initial begin
      en = (88'h1 << EVT_HARD_RESET) | (88'h1 << EVT_CMD_DONE) |
         (88'h1 << EVT_MISSING_CAPS);
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      chk_bit("irq idle", 1'b1, host_irq_n);
      rd_chk("enable reset", OFS_ENABLE, 88'h0);
      rd_chk("clear reset", OFS_CLEAR, 88'h0);
      rd_chk("status reset", OFS_STATUS, 88'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         s_in <= rows[i][55:40];
         repeat (2) @(posedge ref_clk);
         host_model_inst.rd(OFS_STATUS, d, v);
         chk_bit("status valid", 1'b1, v);
         chk_bit("soc late", rows[i][30], d[30]);
         chk_bit("self-test", rows[i][27], d[27]);
         chk_word("legacy", 88'(rows[i][25:24]), 88'(d[25:24]));
         chk_word("host", 88'(rows[i][23:22]), 88'(d[23:22]));
         chk_word("vbus", 88'(rows[i][21:20]), 88'(d[21:20]));
         chk_bit("data role", rows[i][6], d[6]);
         chk_bit("port role", rows[i][5], d[5]);
         chk_bit("orient", rows[i][4], d[4]);
         chk_word("conn", 88'(rows[i][3:1]), 88'(d[3:1]));
         chk_word("status", {48'h0, rows[i][39:0]}, d);
      end
      host_model_inst.wr(OFS_STATUS, {88{1'b1}});
      rd_chk("status read only", OFS_STATUS, 88'h6);
      $display("test status done");
      host_model_inst.wr(OFS_ENABLE, {88{1'b1}});
      rd_chk("enable mask", OFS_ENABLE, EVT_IMPL);
      host_model_inst.wr(OFS_ENABLE, en);
      ev(88'h0, 1'b1, 1'b0);
      chk_bit("irq hard reset", 1'b0, host_irq_n);
      ev(88'h1 << EVT_MISSING_CAPS, 1'b0, 1'b1);
      ev(88'h1 << 38, 1'b0, 1'b0);
      rd_chk("flags", OFS_EVENTS, en);
      host_model_inst.wr(OFS_CLEAR, 88'h1 << EVT_HARD_RESET);
      rd_chk("flags one cleared", OFS_EVENTS, en & ~88'h2);
      // Clear and a new completion land on the same edge
      fork
         host_model_inst.wr(OFS_CLEAR, 88'h1 << EVT_CMD_DONE);
         ev(88'h0, 1'b0, 1'b1);
      join
      rd_chk("set beats clear", OFS_EVENTS, en & ~88'h2);
      host_model_inst.wr(OFS_CLEAR, {88{1'b1}});
      #1;
      chk_bit("irq cleared", 1'b1, host_irq_n);
      $display("test events done");
      host_model_inst.wr(OFS_ENABLE, 88'h0);
      ev(88'h1 << 81, 1'b0, 1'b0);
      chk_bit("irq top byte", 1'b0, host_irq_n);
      host_model_inst.wr(OFS_CLEAR, 88'h1 << 81);
      #1;
      chk_bit("irq top cleared", 1'b1, host_irq_n);
      @(posedge ref_clk);
      custom_enable <= 88'h1 << EVT_MISSING_CAPS;
      ev(88'h1 << EVT_MISSING_CAPS, 1'b0, 1'b0);
      chk_bit("irq custom", 1'b0, host_irq_n);
      $display("test enables done");
      results;
   end
endmodule // testbench
